/* common/exec_pkg.sv */
// constants for the execute stage of a 12-bit instruction core
// assumes a two-cycle fetch/execute pipeline around it
package exec_pkg;
   localparam logic [11:0] OP_IDLE       = 12'h000;
   localparam logic [11:0] OP_LOAD_OPT   = 12'h002;
   localparam logic [11:0] OP_KICK_WDOG  = 12'h004;
   localparam logic [5:0]  OPC_STORE_ACC = 6'h00;  // 0000_001f: bit5, the d bit, set
   localparam logic [5:0]  OPC_CLEAR     = 6'h01;  // 0000_011f with d bit
   localparam logic [5:0]  OPC_DEC       = 6'h03;
   localparam logic [5:0]  OPC_OR_FILE   = 6'h04;
   localparam logic [5:0]  OPC_COPY      = 6'h08;
   localparam logic [5:0]  OPC_INVERT    = 6'h09;
   localparam logic [5:0]  OPC_INC       = 6'h0A;
   localparam logic [5:0]  OPC_DEC_SKIP  = 6'h0B;
   localparam logic [5:0]  OPC_INC_SKIP  = 6'h0F;
   localparam logic [3:0]  OPC_RET_LIT   = 4'h8;
   localparam logic [3:0]  OPC_LOAD_LIT  = 4'hC;
   localparam logic [3:0]  OPC_OR_LIT    = 4'hD;
   localparam logic [2:0]  OPC_JUMP      = 3'h5;
   localparam int          DEST_BIT      = 5;
   localparam int          PAGE_HI_BIT   = 6;
   localparam int          PAGE_LO_BIT   = 5;
   localparam logic [7:0]  ACC_RESET     = 8'h00;
   localparam logic [7:0]  OPTION_RESET  = 8'hFF;
   localparam logic [10:0] PC_RESET      = 11'h7FF;
endpackage

/* verilog/exec_unit.sv */
// execute stage: one instruction per cycle from the fetch stage
// assumes file read data is combinational for the file address given
// Behaviour
// (RQ1) clear file writes zero to the file and sets zero flag
// (RQ2) destination bit one writes file, zero writes accumulator
// (RQ3) invert file gives inverted file to destination, updates zero flag
// (RQ4) decrement-skip subtracts one to destination, status flags unchanged
// (RQ5) decrement-skip zero result flushes fetched instruction, two cycles
// (RQ6) jump loads nine-bit field into counter bits 8..0, two cycles
// (RQ7) jump takes counter bits 10..9 from status bits 6..5
// (RQ8) increment adds one to destination, updates zero flag incl. wrap
// (RQ9) increment-skip leaves flags, zero result flushes next instruction
// (RQ10) or literal ORs accumulator with literal into accumulator, zero flag
// (RQ11) or file ORs accumulator with file to destination, zero flag
// (RQ12) copy file moves file to destination and updates zero flag
// (RQ13) load option copies accumulator into option register, flags untouched
// (RQ14) return literal loads accumulator with the literal
// (RQ15) return literal reloads counter from stack head
// (RQ16) return literal takes two cycles
// (RQ17) kick watchdog clears counter, clears prescaler only when assigned to watchdog, sets expiry and sleep flags
// (RQ18) decrement subtracts one to destination, updates zero flag
// (RQ19) load literal puts literal in accumulator, flags unchanged
// (RQ20) store accumulator writes accumulator to file, flags unchanged
`timescale 1ns/10ps
module exec_unit
   import exec_pkg::*;
(
   input  wire logic        SYS_CLK_IN,
   input  wire logic        SRST_IN,
   input  wire logic [11:0] INSTR_IN,
   input  wire logic        INSTR_VALID_IN,
   input  wire logic [7:0]  FILE_RDATA_IN,
   input  wire logic [7:0]  STATUS_IN,
   input  wire logic [10:0] STACK_HEAD_IN,
   input  wire logic        PRESCALE_TO_WDOG_IN,
   output logic [4:0]       FILE_ADDR_OUT,
   output logic [7:0]       FILE_WDATA_OUT,
   output logic             FILE_WE_OUT,
   output logic [7:0]       ACC_OUT,
   output logic [7:0]       OPTION_OUT,
   output logic [10:0]      PROGRAM_COUNTER_OUT,
   output logic             STACK_POP_OUT,
   output logic             ZERO_FLAG_OUT,
   output logic             ZERO_WE_OUT,
   output logic             WATCHDOG_EXPIRY_FLAG_OUT,
   output logic             SLEEP_ENTERED_FLAG_OUT,
   output logic             WDOG_FLAGS_WE_OUT,
   output logic             WATCHDOG_COUNTER_CLR_OUT,
   output logic             PRESCALER_CLR_OUT,
   output logic             FLUSH_OUT
);

   typedef enum logic [1:0] {
      ST_RUN   = 2'b01,
      ST_FLUSH = 2'b10
   } phase_t;

   phase_t      phase_r;
   phase_t      phase_nxt;
   logic [7:0]  acc_r;
   logic [7:0]  result;
   logic        dest_file;
   logic        acc_we;
   logic        file_we;
   logic        zero_we;
   logic        zero_val;
   logic        skip;
   logic        jump;
   logic        ret;
   logic        opt_we;
   logic        kick;
   logic        live;
   logic [5:0]  op6;
   logic [3:0]  op4;

   assign op6       = INSTR_IN[11:6];
   assign op4       = INSTR_IN[11:8];
   // second cycle of a branch or skip executes an idle op in place of the fetched word
   assign live      = INSTR_VALID_IN && (phase_r == ST_RUN);
   assign dest_file = INSTR_IN[DEST_BIT]; // RQ2

   always_comb begin
      result   = 8'h00;
      acc_we   = 1'b0;
      file_we  = 1'b0;
      zero_we  = 1'b0;
      skip     = 1'b0;
      jump     = 1'b0;
      ret      = 1'b0;
      opt_we   = 1'b0;
      kick     = 1'b0;
      if (live) begin
         if (INSTR_IN[11:9] == OPC_JUMP) begin
            jump = 1'b1; // RQ6
         end else if (op4 == OPC_RET_LIT) begin
            result = INSTR_IN[7:0]; // RQ14
            acc_we = 1'b1;
            ret    = 1'b1; // RQ15
         end else if (op4 == OPC_LOAD_LIT) begin
            result = INSTR_IN[7:0]; // RQ19
            acc_we = 1'b1;
         end else if (op4 == OPC_OR_LIT) begin
            result  = acc_r | INSTR_IN[7:0]; // RQ10
            acc_we  = 1'b1;
            zero_we = 1'b1;
         end else if (INSTR_IN == OP_LOAD_OPT) begin
            opt_we = 1'b1; // RQ13
         end else if (INSTR_IN == OP_KICK_WDOG) begin
            kick = 1'b1; // RQ17
         end else if (op6 == OPC_STORE_ACC && dest_file) begin
            result  = acc_r; // RQ20
            file_we = 1'b1;
         end else if (op6 == OPC_CLEAR && dest_file) begin
            result  = 8'h00; // RQ1
            file_we = 1'b1;
            zero_we = 1'b1;
         end else begin
            unique case (op6)
               OPC_INVERT:   begin result = ~FILE_RDATA_IN;        zero_we = 1'b1; end // RQ3
               OPC_DEC:      begin result = FILE_RDATA_IN - 8'h01; zero_we = 1'b1; end // RQ18
               OPC_INC:      begin result = FILE_RDATA_IN + 8'h01; zero_we = 1'b1; end // RQ8
               OPC_OR_FILE:  begin result = acc_r | FILE_RDATA_IN; zero_we = 1'b1; end // RQ11
               OPC_COPY:     begin result = FILE_RDATA_IN;         zero_we = 1'b1; end // RQ12
               OPC_DEC_SKIP: begin result = FILE_RDATA_IN - 8'h01; end // RQ4
               OPC_INC_SKIP: begin result = FILE_RDATA_IN + 8'h01; end // RQ9
               default:      begin result = 8'h00; end
            endcase
            if (op6 == OPC_INVERT || op6 == OPC_DEC || op6 == OPC_INC || op6 == OPC_OR_FILE
                || op6 == OPC_COPY || op6 == OPC_DEC_SKIP || op6 == OPC_INC_SKIP) begin
               file_we = dest_file; // RQ2
               acc_we  = !dest_file;
            end
            skip = (op6 == OPC_DEC_SKIP || op6 == OPC_INC_SKIP) && (result == 8'h00); // RQ5 RQ9
         end
      end
      zero_val = (result == 8'h00);
   end

   // any flow change spends the next cycle flushing
   always_comb begin
      phase_nxt = (skip || jump || ret) ? ST_FLUSH : ST_RUN; // RQ5 RQ16
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (SRST_IN) begin
         phase_r <= ST_RUN;
      end else begin
         phase_r <= phase_nxt;
      end
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (SRST_IN) begin
         acc_r <= ACC_RESET;
      end else if (acc_we) begin
         acc_r <= result;
      end
   end
   assign ACC_OUT = acc_r;

   always_ff @(posedge SYS_CLK_IN) begin
      if (SRST_IN) begin
         FILE_ADDR_OUT  <= 5'h00;
         FILE_WDATA_OUT <= 8'h00;
         FILE_WE_OUT    <= 1'b0;
      end else begin
         FILE_ADDR_OUT  <= INSTR_IN[4:0];
         FILE_WDATA_OUT <= result;
         FILE_WE_OUT    <= file_we; // RQ2
      end
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (SRST_IN) begin
         ZERO_FLAG_OUT <= 1'b0;
         ZERO_WE_OUT   <= 1'b0;
      end else begin
         ZERO_FLAG_OUT <= zero_val; // RQ1 RQ8
         ZERO_WE_OUT   <= zero_we;
      end
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (SRST_IN) begin
         OPTION_OUT <= OPTION_RESET;
      end else if (opt_we) begin
         OPTION_OUT <= acc_r; // RQ13
      end
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (SRST_IN) begin
         PROGRAM_COUNTER_OUT <= PC_RESET;
         STACK_POP_OUT       <= 1'b0;
      end else begin
         STACK_POP_OUT <= ret;
         if (jump) begin
            PROGRAM_COUNTER_OUT <= {STATUS_IN[PAGE_HI_BIT], STATUS_IN[PAGE_LO_BIT],
                                    INSTR_IN[8:0]}; // RQ6 RQ7
         end else if (ret) begin
            PROGRAM_COUNTER_OUT <= STACK_HEAD_IN; // RQ15
         end else if (INSTR_VALID_IN) begin
            PROGRAM_COUNTER_OUT <= PROGRAM_COUNTER_OUT + 11'h001;
         end
      end
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (SRST_IN) begin
         WATCHDOG_EXPIRY_FLAG_OUT <= 1'b1;
         SLEEP_ENTERED_FLAG_OUT   <= 1'b1;
         WDOG_FLAGS_WE_OUT        <= 1'b0;
         WATCHDOG_COUNTER_CLR_OUT <= 1'b0;
         PRESCALER_CLR_OUT        <= 1'b0;
      end else begin
         WATCHDOG_EXPIRY_FLAG_OUT <= 1'b1; // RQ17
         SLEEP_ENTERED_FLAG_OUT   <= 1'b1;
         WDOG_FLAGS_WE_OUT        <= kick;
         WATCHDOG_COUNTER_CLR_OUT <= kick;
         PRESCALER_CLR_OUT        <= kick && PRESCALE_TO_WDOG_IN;
      end
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (SRST_IN) begin
         FLUSH_OUT <= 1'b0;
      end else begin
         FLUSH_OUT <= (phase_nxt == ST_FLUSH);
      end
   end

   // the skipping op itself may still write back; only the slot after it must stay silent
   sequence seq_flush_slot;
      FLUSH_OUT && (phase_r == ST_FLUSH);
   endsequence

   sequence seq_slot_quiet;
      !FILE_WE_OUT && !ZERO_WE_OUT && !STACK_POP_OUT && !WDOG_FLAGS_WE_OUT && $stable(ACC_OUT);
   endsequence

   chk_skip_flush: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN) // RQ5
      skip |=> seq_flush_slot ##1 seq_slot_quiet)
      else $error("skip did not flush next slot");

   chk_jump_target: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN) // RQ7
      jump |=> PROGRAM_COUNTER_OUT == {$past(STATUS_IN[6:5]), $past(INSTR_IN[8:0])})
      else $error("jump target wrong");

   chk_ret_pc: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN) // RQ15
      ret |=> PROGRAM_COUNTER_OUT == $past(STACK_HEAD_IN) && ACC_OUT == $past(INSTR_IN[7:0]))
      else $error("return did not load counter and accumulator");

   chk_two_cycle: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN) // RQ16
      (jump || ret) |=> seq_flush_slot ##1 seq_slot_quiet)
      else $error("branch did not take two cycles");

   chk_skip_flags: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN) // RQ4
      (live && (op6 == OPC_DEC_SKIP || op6 == OPC_INC_SKIP)) |=> !ZERO_WE_OUT)
      else $error("skip op touched status");

   chk_clear_zero: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN) // RQ1
      (live && op6 == OPC_CLEAR && dest_file) |=> FILE_WE_OUT && FILE_WDATA_OUT == 8'h00
      && ZERO_WE_OUT && ZERO_FLAG_OUT)
      else $error("clear file wrong");

   chk_option_load: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN) // RQ13
      opt_we |=> OPTION_OUT == $past(acc_r) && !ZERO_WE_OUT)
      else $error("option load wrong");

   chk_kick_flags: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN) // RQ17
      kick |=> WATCHDOG_COUNTER_CLR_OUT && WDOG_FLAGS_WE_OUT && WATCHDOG_EXPIRY_FLAG_OUT
      && SLEEP_ENTERED_FLAG_OUT)
      else $error("watchdog kick wrong");

   chk_prescale_clr: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN) // RQ17
      kick |=> PRESCALER_CLR_OUT == $past(PRESCALE_TO_WDOG_IN))
      else $error("prescaler clear wrong");

   chk_inc_wrap: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN) // RQ8
      (live && op6 == OPC_INC && FILE_RDATA_IN == 8'hFF) |=> ZERO_WE_OUT && ZERO_FLAG_OUT)
      else $error("increment wrap lost zero");

   chk_dest_write: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN) // RQ2
      (live && op6 == OPC_INC) |=> FILE_WE_OUT == $past(dest_file)
      && FILE_ADDR_OUT == $past(INSTR_IN[4:0])
      && (FILE_WE_OUT || ACC_OUT == $past(FILE_RDATA_IN) + 8'h01))
      else $error("destination select wrong");

   chk_invert_dest: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN) // RQ3
      (live && op6 == OPC_INVERT) |=> FILE_WE_OUT == $past(dest_file)
      && (FILE_WE_OUT ? FILE_WDATA_OUT : ACC_OUT) == ~$past(FILE_RDATA_IN))
      else $error("invert result wrong");

   chk_store_acc: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN) // RQ20
      (live && op6 == OPC_STORE_ACC && dest_file) |=> FILE_WE_OUT
      && FILE_WDATA_OUT == $past(acc_r) && !ZERO_WE_OUT)
      else $error("store accumulator wrong");

   chk_literal_load: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN) // RQ19
      (live && op4 == OPC_LOAD_LIT) |=> ACC_OUT == $past(INSTR_IN[7:0]) && !ZERO_WE_OUT)
      else $error("literal load wrong");

   chk_or_literal: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN) // RQ10
      (live && op4 == OPC_OR_LIT) |=> ZERO_WE_OUT
      && ACC_OUT == ($past(acc_r) | $past(INSTR_IN[7:0]))
      && ZERO_FLAG_OUT == (ACC_OUT == 8'h00))
      else $error("or literal wrong");

   chk_or_file: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN) // RQ11
      (live && op6 == OPC_OR_FILE) |=> ZERO_WE_OUT
      && ZERO_FLAG_OUT == (($past(acc_r) | $past(FILE_RDATA_IN)) == 8'h00))
      else $error("or file zero flag wrong");

   chk_copy_zero: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN) // RQ12
      (live && op6 == OPC_COPY) |=> ZERO_WE_OUT
      && ZERO_FLAG_OUT == ($past(FILE_RDATA_IN) == 8'h00))
      else $error("copy zero flag wrong");

   chk_dec_zero: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN) // RQ18
      (live && op6 == OPC_DEC) |=> ZERO_WE_OUT
      && ZERO_FLAG_OUT == ($past(FILE_RDATA_IN) == 8'h01))
      else $error("decrement zero flag wrong");

endmodule

/* test/clear_to_return_op_execute_bench.sv */
// self-checking bench for the execute stage, driving every port directly
// assumes registered outputs one edge after each taken instruction
`timescale 1ns/10ps
module clear_to_return_op_execute_bench;
   import exec_pkg::*;
   logic        clk, srst, valid, psa, f_we, pop, zf, zwe, exf, slf, wfw, wclr, pclr, flush;
   logic [11:0] instr;
   logic [7:0]  rdata, status, f_wd, acc, opt, acc_e, e, rd;
   logic [5:0]  op;
   logic [10:0] stack, pc;
   logic [4:0]  f_ad;
   logic [5:0]  ops [5] = '{OPC_INVERT, OPC_DEC, OPC_INC, OPC_OR_FILE, OPC_COPY};
   int          err_count, total_checks;
   exec_unit dut_u (.SYS_CLK_IN(clk), .SRST_IN(srst), .INSTR_IN(instr),
      .INSTR_VALID_IN(valid), .FILE_RDATA_IN(rdata), .STATUS_IN(status),
      .STACK_HEAD_IN(stack), .PRESCALE_TO_WDOG_IN(psa), .FILE_ADDR_OUT(f_ad),
      .FILE_WDATA_OUT(f_wd), .FILE_WE_OUT(f_we), .ACC_OUT(acc), .OPTION_OUT(opt),
      .PROGRAM_COUNTER_OUT(pc), .STACK_POP_OUT(pop), .ZERO_FLAG_OUT(zf),
      .ZERO_WE_OUT(zwe), .WATCHDOG_EXPIRY_FLAG_OUT(exf), .SLEEP_ENTERED_FLAG_OUT(slf),
      .WDOG_FLAGS_WE_OUT(wfw), .WATCHDOG_COUNTER_CLR_OUT(wclr),
      .PRESCALER_CLR_OUT(pclr), .FLUSH_OUT(flush));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task print_verdict();
      if (err_count == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task cmp_bit(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: flag %b, expected %b", $time, got, exp);
      end
   endtask
   task cmp_word(input logic [10:0] got, input logic [10:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: value %h, expected %h", $time, got, exp);
      end
   endtask
   // inputs always change 1 ns after the rising edge
   task step(input logic [11:0] i, input logic [7:0] rd);
      instr = i;
      rdata = rd;
      @(posedge clk);
      #1;
   endtask
   task chk_out(input logic we, input logic [7:0] wd, input logic zw, input logic z);
      cmp_bit(f_we, we);
      if (we) cmp_word(11'(f_wd), 11'(wd));
      cmp_bit(zwe, zw);
      if (zw) cmp_bit(zf, z);
      cmp_word(11'(acc), 11'(acc_e));
   endtask
   task do_reset();
      srst = 1'b1;
      repeat (5) @(posedge clk);
      #1;
      srst = 1'b0;
      acc_e = ACC_RESET;
      chk_out(1'b0, 8'h00, 1'b0, 1'b0);
      cmp_word(11'(opt), 11'(OPTION_RESET));
      cmp_word(pc, PC_RESET);
      cmp_bit(flush | pop | wfw | wclr | pclr, 1'b0);
      cmp_bit(exf & slf, 1'b1);
   endtask
   function automatic logic [7:0] fres(input logic [5:0] o, input logic [7:0] r,
                                       input logic [7:0] a);
      case (o)
         OPC_INVERT: fres = ~r;
         OPC_DEC, OPC_DEC_SKIP: fres = r - 8'h01;
         OPC_INC, OPC_INC_SKIP: fres = r + 8'h01;
         OPC_OR_FILE: fres = r | a;
         default: fres = r;
      endcase
   endfunction
   initial begin
      #5000;
      err_count++;
      print_verdict();
   end
   initial begin
      {srst, valid, psa, instr, rdata, status, stack} = '0;
      err_count = 0;
      total_checks = 0;
      valid = 1'b1;
      do_reset();
      step({OPC_LOAD_LIT, 8'h5A}, 8'h00);
      acc_e = 8'h5A;
      chk_out(1'b0, 8'h00, 1'b0, 1'b0);
      cmp_word(pc, 11'h000);
      step(12'h023, 8'h00);
      chk_out(1'b1, 8'h5A, 1'b0, 1'b0);
      cmp_word(11'(f_ad), 11'h003);
      step(OP_LOAD_OPT, 8'h00);
      chk_out(1'b0, 8'h00, 1'b0, 1'b0);
      cmp_word(11'(opt), 11'h05A);
      step({OPC_CLEAR, 1'b1, 5'h05}, 8'h3C);
      chk_out(1'b1, 8'h00, 1'b1, 1'b1);
      for (int o = 0; o < 5; o++) begin
         for (int d = 0; d < 2; d++) begin
            for (int r = 0; r < 2; r++) begin
               rd = r ? 8'h01 : 8'hFF;
               e = fres(ops[o], rd, acc_e);
               step({ops[o], d[0], 5'(o + 16)}, rd);
               if (d == 0) acc_e = e;
               chk_out(d[0], e, 1'b1, e == 8'h00);
               if (d == 1) cmp_word(11'(f_ad), 11'(o + 16));
            end
         end
      end
      // odd s: result reaches zero (01 decremented, FF wrapped) and is written back, so the skip is taken
      for (int s = 0; s < 4; s++) begin
         rd = s[0] ? (s[1] ? 8'hFF : 8'h01) : 8'h05;
         op = s[1] ? OPC_INC_SKIP : OPC_DEC_SKIP;
         e = fres(op, rd, 8'h00);
         step({op, s[0], 5'h07}, rd);
         if (!s[0]) acc_e = e;
         chk_out(s[0], e, 1'b0, 1'b0);
         cmp_bit(flush, e == 8'h00);
         step({OPC_LOAD_LIT, 8'h77}, 8'h00);
         if (e != 8'h00) acc_e = 8'h77;
         cmp_word(11'(acc), 11'(acc_e));
      end
      step({OPC_LOAD_LIT, 8'h00}, 8'h00);
      step({OPC_OR_LIT, 8'h00}, 8'h00);
      acc_e = 8'h00;
      chk_out(1'b0, 8'h00, 1'b1, 1'b1);
      step({OPC_OR_LIT, 8'h81}, 8'h00);
      acc_e = 8'h81;
      chk_out(1'b0, 8'h00, 1'b1, 1'b0);
      status = 8'h40;
      step({OPC_JUMP, 9'h1A5}, 8'h00);
      cmp_word(pc, 11'h5A5);
      cmp_bit(flush, 1'b1);
      step({OPC_LOAD_LIT, 8'h22}, 8'h00);
      cmp_word(11'(acc), 11'(acc_e));
      stack = 11'h2B7;
      step({OPC_RET_LIT, 8'hC3}, 8'h00);
      acc_e = 8'hC3;
      chk_out(1'b0, 8'h00, 1'b0, 1'b0);
      cmp_word(pc, 11'h2B7);
      cmp_bit(pop & flush, 1'b1);
      step({OPC_LOAD_LIT, 8'h33}, 8'h00);
      cmp_word(11'(acc), 11'(acc_e));
      for (int p = 0; p < 2; p++) begin
         psa = p[0];
         step(OP_KICK_WDOG, 8'h00);
         cmp_bit(wclr & wfw & exf & slf, 1'b1);
         cmp_bit(pclr, p[0]);
      end
      step(OP_IDLE, 8'h00);
      chk_out(1'b0, 8'h00, 1'b0, 1'b0);
      valid = 1'b0;
      step({OPC_LOAD_LIT, 8'h11}, 8'h00);
      cmp_word(11'(acc), 11'(acc_e));
      valid = 1'b1;
      do_reset();
      print_verdict();
   end
endmodule
